// ### iopb_pkg.sv
// Purpose: shared constants for the port and external bus block
// Assumes: one 50 MHz clock, synchronous active-high system reset
// Notes: port mode encodings are local to this block
package iopb_pkg;
  localparam int unsigned IOPB_CLK_HZ = 50_000_000;
  localparam int unsigned IOPB_RST_FILT_CLKS = 4;
  localparam int unsigned IOPB_RST_LATCH_CLKS = 5;
  localparam int unsigned IOPB_RST_HOLD_CLKS = 18;
  localparam logic [15:0] IOPB_START_ADDR = 16'h000C;
  localparam logic [15:0] IOPB_ROM_TOP = 16'h2000;
  localparam logic [15:0] IOPB_ONE_PAGE = 16'h0100;
  // first port nibble modes
  localparam logic [1:0] IOPB_NIB_IN = 2'h0;
  localparam logic [1:0] IOPB_NIB_OUT = 2'h1;
  localparam logic [1:0] IOPB_NIB_ADDR = 2'h2;
  // second port modes
  localparam logic [1:0] IOPB_BYTE_IN = 2'h0;
  localparam logic [1:0] IOPB_BYTE_OUT = 2'h1;
  localparam logic [1:0] IOPB_BYTE_BUS = 2'h2;
  typedef enum logic [3:0] {
    IOPB_BUS_IDLE = 4'h1,
    IOPB_BUS_ADDR = 4'h2,
    IOPB_BUS_STRB = 4'h4,
    IOPB_BUS_DONE = 4'h8
  } iopb_bus_e;
endpackage

// ### iopb_rst_filt.sv
// Purpose: filters the external low-active reset and stretches the internal reset
// Assumes: reset pin already synchronous to i_clk
// Notes: short glitches never reach the core
`timescale 1ns/10ps
module iopb_rst_filt
  import iopb_pkg::*;
#(
  parameter int unsigned FILT = IOPB_RST_FILT_CLKS,
  parameter int unsigned HOLD = IOPB_RST_HOLD_CLKS
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // pin and result
  input wire logic i_ext_rst_n,
  output logic o_core_rst,
  output logic o_core_rst_rise
);
  initial begin
    if (FILT < 1 || HOLD < 1 || FILT >= 32 || HOLD >= 32) $error("iopb_rst_filt bad counts");
  end
  typedef struct packed {
    logic [4:0] low_cnt;
    logic [4:0] hold_cnt;
    logic rst;
  } iopb_rf_s;
  iopb_rf_s s_q, s_d;
  always_comb begin
    s_d = s_q;
    if (i_ext_rst_n) begin
      s_d.low_cnt = '0;
    end else if (s_q.low_cnt != 5'h1F) begin
      s_d.low_cnt = s_q.low_cnt + 5'h01;
    end
    // latch on the fifth clock of a low that outlived the filter
    if (!i_ext_rst_n && s_q.low_cnt == 5'(FILT)) begin
      s_d.rst = 1'b1;
      s_d.hold_cnt = 5'(HOLD);
    end else if (s_q.rst) begin
      if (s_q.hold_cnt != 5'h00) begin
        s_d.hold_cnt = s_q.hold_cnt - 5'h01;
      end
      // release only on an edge once both the count and the pin are done
      if ((s_q.hold_cnt <= 5'h01) && i_ext_rst_n) begin
        s_d.rst = 1'b0;
      end
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign o_core_rst = s_q.rst;
  assign o_core_rst_rise = s_d.rst && !s_q.rst;
endmodule

// ### iopb_top.sv
// Purpose: three parallel ports, external memory bus, handshake lines, reset filter
// Assumes: core requests one transfer at a time; all pins synchronous to i_clk
// Notes: two-way pins are split into in, out and output enable
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
module iopb_top
  import iopb_pkg::*;
#(
  parameter int unsigned EXT_WAIT = 2
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ext_rst_n,
  input wire logic i_rom_disable_n,
  // core configuration
  input wire logic [1:0] i_lo_nib_mode,
  input wire logic [1:0] i_hi_nib_mode,
  input wire logic [1:0] i_byte_mode,
  input wire logic [7:0] i_bit_dir_out,
  input wire logic i_open_drain,
  input wire logic i_hs0_en,
  input wire logic i_hs1_en,
  input wire logic i_hs2_en,
  input wire logic i_share_en,
  input wire logic i_float_req,
  input wire logic i_ext_timing_clr,
  // core port data
  input wire logic [7:0] i_wr_p0,
  input wire logic [7:0] i_wr_p1,
  input wire logic [7:0] i_wr_p2,
  output logic [7:0] o_rd_p0,
  output logic [7:0] o_rd_p1,
  output logic [7:0] o_rd_p2,
  // core memory request
  input wire logic i_mem_req,
  input wire logic i_mem_wr,
  input wire logic [15:0] i_mem_addr,
  input wire logic [7:0] i_mem_wdata,
  output logic o_mem_ready,
  output logic [7:0] o_mem_rdata,
  output logic o_mem_internal,
  // core reset status
  output logic o_core_rst,
  output logic o_ext_timing,
  output logic [15:0] o_start_pc,
  // bus strobes
  output logic o_transfer_strobe_n,
  output logic o_addr_latch_strobe_n,
  output logic o_rd_wr_n,
  output logic o_strobe_oe,
  // port pins
  input wire logic [7:0] i_high_addr_port_lines,
  output logic [7:0] o_high_addr_port_lines,
  output logic [7:0] o_high_addr_port_oe,
  input wire logic [7:0] i_muxed_bus_port_lines,
  output logic [7:0] o_muxed_bus_port_lines,
  output logic [7:0] o_muxed_bus_port_oe,
  input wire logic [7:0] i_bit_io_port_lines,
  output logic [7:0] o_bit_io_port_lines,
  output logic [7:0] o_bit_io_port_oe,
  // control lines
  input wire logic i_ctl_line_1,
  input wire logic i_ctl_line_2,
  input wire logic i_ctl_line_3,
  output logic o_ctl_line_4,
  output logic o_ctl_line_5,
  output logic o_ctl_line_6
);
  initial begin
    if (EXT_WAIT < 1 || EXT_WAIT > 15) $error("iopb_top bad EXT_WAIT");
  end
  //////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    iopb_bus_e st;
    logic [3:0] wait_cnt;
    logic as_n;
    logic ds_n;
    logic rw_n;
    logic [7:0] p0_out;
    logic [7:0] p1_out;
    logic [7:0] rdata;
    logic ext_timing;
    logic rom_off;
    logic rst_as;
    logic [15:0] pc;
    logic [7:0] p0_in;
    logic [7:0] p1_in;
    logic [7:0] p2_in;
  } iopb_top_s;
  iopb_top_s s_q, s_d;
  logic core_rst;
  logic core_rst_rise;
  iopb_rst_filt #(
    .FILT(IOPB_RST_FILT_CLKS),
    .HOLD(IOPB_RST_HOLD_CLKS)
  ) u_rst_filt (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_ext_rst_n(i_ext_rst_n),
    .o_core_rst(core_rst),
    .o_core_rst_rise(core_rst_rise)
  );
  //////////////////////////////////////////////////////////////////////////////
  logic [1:0] lo_mode, hi_mode, b_mode;
  logic floated, ext_addr, hs0_ok, hs0_in, hs2_in;
  always_comb begin
    // rom-disabled reset forces both nibbles to address until software clears extended timing
    lo_mode = s_q.rom_off && s_q.ext_timing ? IOPB_NIB_ADDR : i_lo_nib_mode;
    hi_mode = s_q.rom_off && s_q.ext_timing ? IOPB_NIB_ADDR : i_hi_nib_mode;
    b_mode = s_q.rom_off ? IOPB_BYTE_BUS : i_byte_mode;
    // float when software asks or when another master holds acknowledge
    floated = i_float_req || (i_share_en && i_ctl_line_3);
    // rom disabled sends every address out; otherwise only above the rom
    ext_addr = s_q.rom_off || (i_mem_addr >= IOPB_ROM_TOP);
    hs0_ok = i_hs0_en && (lo_mode == hi_mode) && (hi_mode != IOPB_NIB_ADDR);
    hs0_in = (hi_mode == IOPB_NIB_IN);
    hs2_in = !i_bit_dir_out[7];
  end
  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    s_d.p0_in = i_high_addr_port_lines;
    s_d.p1_in = i_muxed_bus_port_lines;
    s_d.p2_in = i_bit_io_port_lines;
    if (i_ext_timing_clr) begin
      s_d.ext_timing = 1'b0;
    end
    if (core_rst) begin
      // strobe held low, address strobe toggles once per clock during reset
      s_d.st = IOPB_BUS_IDLE;
      s_d.ds_n = 1'b0;
      s_d.as_n = 1'b1;
      s_d.rst_as = !s_q.rst_as;
      s_d.rw_n = 1'b1;
      s_d.pc = IOPB_START_ADDR;
      s_d.rom_off = !i_rom_disable_n;
      s_d.ext_timing = !i_rom_disable_n;
    end else begin
      s_d.rst_as = 1'b1;
      unique case (s_q.st)
        IOPB_BUS_IDLE: begin
          s_d.ds_n = 1'b1;
          s_d.as_n = 1'b1;
          if (i_mem_req && ext_addr && !floated) begin
            s_d.st = IOPB_BUS_ADDR;
            s_d.as_n = 1'b0;
            s_d.rw_n = !i_mem_wr;
            s_d.p0_out = i_mem_addr[15:8];
            s_d.p1_out = i_mem_addr[7:0];
            s_d.pc = i_mem_addr;
          end
        end
        IOPB_BUS_ADDR: begin
          // address strobe rises here with the address still on the bus
          s_d.as_n = 1'b1;
          s_d.ds_n = 1'b0;
          s_d.st = IOPB_BUS_STRB;
          s_d.wait_cnt = s_q.ext_timing ? 4'(EXT_WAIT) : 4'h0;
          if (!s_q.rw_n) begin
            s_d.p1_out = i_mem_wdata;
          end
        end
        IOPB_BUS_STRB: begin
          if (s_q.wait_cnt != 4'h0) begin
            s_d.wait_cnt = s_q.wait_cnt - 4'h1;
          end else begin
            // read data taken in the last cycle before the strobe rises
            s_d.rdata = i_muxed_bus_port_lines;
            s_d.ds_n = 1'b1;
            s_d.st = IOPB_BUS_DONE;
          end
        end
        IOPB_BUS_DONE: begin
          s_d.rw_n = 1'b1;
          s_d.st = IOPB_BUS_IDLE;
        end
        default: begin
          s_d.st = IOPB_BUS_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      s_q <= '{
        st: IOPB_BUS_IDLE,
        wait_cnt: 4'h0,
        as_n: 1'b1,
        ds_n: 1'b1,
        rw_n: 1'b1,
        p0_out: 8'h00,
        p1_out: 8'h00,
        rdata: 8'h00,
        ext_timing: 1'b0,
        rom_off: 1'b0,
        rst_as: 1'b1,
        pc: IOPB_START_ADDR,
        p0_in: 8'h00,
        p1_in: 8'h00,
        p2_in: 8'h00
      };
    end else begin
      s_q <= s_d;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  logic bus_busy;
  assign bus_busy = (s_q.st != IOPB_BUS_IDLE);
  assign o_mem_ready = (s_q.st == IOPB_BUS_DONE) || (i_mem_req && !ext_addr && !core_rst);
  assign o_mem_rdata = s_q.rdata;
  assign o_mem_internal = !ext_addr;
  assign o_core_rst = core_rst;
  assign o_ext_timing = s_q.ext_timing;
  assign o_start_pc = s_q.pc;
  assign o_transfer_strobe_n = s_q.ds_n;
  assign o_addr_latch_strobe_n = core_rst ? s_q.rst_as : s_q.as_n;
  assign o_rd_wr_n = s_q.rw_n;
  assign o_strobe_oe = !floated || core_rst;
  // first port: each nibble io or address
  logic [7:0] p0_pin, p0_oe;
  always_comb begin
    p0_pin = i_wr_p0;
    p0_oe = 8'h00;
    if (hi_mode == IOPB_NIB_ADDR) begin
      // upper nibble carries the top address bits whenever its mode is address, released while floated
      p0_pin[7:4] = s_q.p0_out[7:4];
      p0_oe[7:4] = {4{!floated}};
    end else if (hi_mode == IOPB_NIB_OUT) begin
      p0_oe[7:4] = 4'hF;
    end
    if (lo_mode == IOPB_NIB_ADDR) begin
      p0_pin[3:0] = s_q.p0_out[3:0];
      p0_oe[3:0] = {4{!floated}};
    end else if (lo_mode == IOPB_NIB_OUT) begin
      p0_oe[3:0] = 4'hF;
    end
  end
  assign o_high_addr_port_lines = p0_pin;
  assign o_high_addr_port_oe = p0_oe;
  assign o_rd_p0 = s_q.p0_in;
  // second port: byte io or multiplexed address then data
  assign o_muxed_bus_port_lines = (b_mode == IOPB_BYTE_BUS) ? s_q.p1_out : i_wr_p1;
  assign o_muxed_bus_port_oe = {8{(b_mode == IOPB_BYTE_OUT) || (b_mode == IOPB_BYTE_BUS &&
    !floated && bus_busy && (s_q.st == IOPB_BUS_ADDR || !s_q.rw_n || !s_q.as_n))}};
  assign o_rd_p1 = s_q.p1_in;
  // third port: always io, open drain drives only the low level
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bit
      assign o_bit_io_port_lines[gi] = i_open_drain ? 1'b0 : i_wr_p2[gi];
      assign o_bit_io_port_oe[gi] = i_bit_dir_out[gi] && (!i_open_drain || !i_wr_p2[gi]);
    end
  endgenerate
  assign o_rd_p2 = s_q.p2_in;
  // handshake outputs: output direction drives data available low, input drives ready
  logic hs0_line, hs1_line, hs2_line;
  always_comb begin
    hs0_line = 1'b1;
    hs1_line = 1'b1;
    hs2_line = 1'b1;
    if (hs0_ok) begin
      hs0_line = hs0_in;
    end
    if (i_share_en) begin
      // request is a level held low while the core wants the bus, not a pulse
      hs1_line = !i_mem_req;
    end else if (i_hs1_en) begin
      hs1_line = (b_mode != IOPB_BYTE_OUT);
    end
    if (i_hs2_en) begin
      hs2_line = hs2_in;
    end
  end
  assign o_ctl_line_5 = hs0_line;
  assign o_ctl_line_4 = hs1_line;
  assign o_ctl_line_6 = hs2_line;
  // lines 1 and 2 only matter for sequenced handshakes, which static levels never need
  logic unused_in;
  assign unused_in = i_ctl_line_1 ^ i_ctl_line_2 ^ core_rst_rise;
endmodule

// ### iopb_properties.sv
// Purpose: pin checks on bus strobes and reset of the port block
// Assumes: one clock, synchronous reset
// Notes: run counters replace long repetitions
`timescale 1ns/10ps
module iopb_properties
  import iopb_pkg::*;
(
  // clock, reset and core side
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ext_rst_n,
  input wire logic i_mem_wr,
  input wire logic i_float_req,
  input wire logic i_share_en,
  input wire logic i_ctl_line_3,
  input wire logic o_mem_ready,
  input wire logic o_core_rst,
  input wire logic [15:0] o_start_pc,
  // bus pins
  input wire logic o_rd_wr_n,
  input wire logic o_transfer_strobe_n,
  input wire logic o_addr_latch_strobe_n,
  input wire logic o_strobe_oe
);
  ////////////////////////////////////////
  logic [7:0] low_run_q;
  logic [7:0] rst_run_q;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      low_run_q <= 8'h00;
      rst_run_q <= 8'h00;
    end else begin
      low_run_q <= i_ext_rst_n ? 8'h00 : low_run_q + 8'h01;
      rst_run_q <= o_core_rst ? rst_run_q + 8'h01 : 8'h00;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // reset also toggles the address strobe, so takes count only outside it
  sequence s_take;
    $fell(o_addr_latch_strobe_n) && !o_core_rst && !$past(o_core_rst);
  endsequence
  sequence s_data;
    $rose(o_addr_latch_strobe_n) && $fell(o_transfer_strobe_n);
  endsequence
  a_strobe_order: assert property (s_take |=> s_data)
    else $error("strobe order");
  a_rw_level: assert property (s_take |-> o_rd_wr_n == !i_mem_wr)
    else $error("rw level");
  a_rw_release: assert property (o_mem_ready |=> o_rd_wr_n)
    else $error("rw release");
  a_rst_filter: assert property ($rose(o_core_rst) |-> low_run_q >= 8'h05)
    else $error("reset from short low");
  a_rst_hold: assert property ($fell(o_core_rst) |-> rst_run_q >= 8'h12 && $past(i_ext_rst_n))
    else $error("reset released early");
  a_rst_strobes: assert property (o_core_rst && $past(o_core_rst) |->
    !o_transfer_strobe_n && o_addr_latch_strobe_n != $past(o_addr_latch_strobe_n))
    else $error("strobes in reset");
  a_start_pc: assert property ($fell(o_core_rst) |-> o_start_pc == IOPB_START_ADDR)
    else $error("start address");
  a_float_bus: assert property (i_float_req || i_share_en && i_ctl_line_3 |-> !o_strobe_oe)
    else $error("bus not floated");
endmodule

// ### iopb_ext_mem.sv
// Purpose: external byte memory on the multiplexed bus
// Assumes: no pull on the bus, so a released bus toggles
// Notes: unwritten bytes read back as address high xor low
`timescale 1ns/10ps
module iopb_ext_mem (
  // bus pins seen from memory
  input wire logic i_clk,
  input wire logic i_as_n,
  input wire logic i_ds_n,
  input wire logic i_rw_n,
  input wire logic [7:0] i_hi,
  input wire logic [7:0] i_ad,
  // data driven back
  output logic [7:0] o_ad
);
  ////////////////////////////////////////
  logic [7:0] mem [0:65535];
  bit [65535:0] seen_q;
  logic [15:0] a_q = 16'h0000;
  logic [7:0] l_q = 8'h00;
  always @(posedge i_clk) begin
    l_q <= o_ad;
    if (!i_as_n) a_q <= {i_hi, i_ad};
    if (!i_ds_n && !i_rw_n) begin
      mem[a_q] <= i_ad;
      seen_q[a_q] <= 1'b1;
    end
  end
  // data stands for the whole low strobe, so it is valid before the rise
  always_comb begin
    if (!i_ds_n && i_rw_n) o_ad = seen_q[a_q] ? mem[a_q] : a_q[7:0] ^ a_q[15:8];
    else o_ad = ~l_q;
  end
endmodule

// ### iopb_tb.sv
// Purpose: self-checking bench for the port and external bus block
// Assumes: partner memory answers every external transfer
// Notes: handshake lines are static levels, so they stay tied
`timescale 1ns/10ps
bind iopb_top iopb_properties u_props (.i_clk, .i_sys_rst, .i_ext_rst_n, .i_mem_wr, .i_float_req,
  .i_share_en, .i_ctl_line_3, .o_mem_ready, .o_core_rst, .o_start_pc, .o_rd_wr_n,
  .o_transfer_strobe_n, .o_addr_latch_strobe_n, .o_strobe_oe);
module testbench;
  import iopb_pkg::*;
  logic i_clk, i_sys_rst, i_ext_rst_n, i_rom_disable_n, i_open_drain, i_hs0_en, i_hs1_en;
  logic i_hs2_en, i_share_en, i_float_req, i_ext_timing_clr, i_mem_req, i_mem_wr, o_ctl_line_4;
  logic i_ctl_line_1, i_ctl_line_2, i_ctl_line_3, o_mem_ready, o_mem_internal, o_core_rst;
  logic o_ext_timing, o_transfer_strobe_n, o_addr_latch_strobe_n, o_rd_wr_n, o_strobe_oe;
  logic [1:0] i_lo_nib_mode, i_hi_nib_mode, i_byte_mode;
  logic [7:0] i_bit_dir_out, i_wr_p0, i_wr_p1, i_wr_p2, i_high_addr_port_lines, i_mem_wdata;
  logic [7:0] i_muxed_bus_port_lines, i_bit_io_port_lines, o_mem_rdata, o_high_addr_port_lines;
  logic [7:0] o_high_addr_port_oe, o_muxed_bus_port_lines, o_muxed_bus_port_oe, mem_ad;
  logic [7:0] o_bit_io_port_lines, o_bit_io_port_oe;
  logic [15:0] i_mem_addr, o_start_pc;
  logic [7:0] o_rd_p0, o_rd_p1, o_rd_p2;
  logic o_ctl_line_5, o_ctl_line_6;
  // extended timing wait states, and falling edges counted from request to ready without them
  localparam int unsigned WAITS = 2;
  localparam int unsigned EXT_CYC = 4;
  logic [7:0] exp_q[$];
  int miscompares = 0;
  int checked = 0;
  ////////////////////////////////////////
  assign i_muxed_bus_port_lines = (o_muxed_bus_port_oe & o_muxed_bus_port_lines)
    | (~o_muxed_bus_port_oe & mem_ad);
  iopb_top #(.EXT_WAIT(WAITS)) iopb_top_i (.i_clk, .i_sys_rst, .i_ext_rst_n, .i_rom_disable_n,
    .i_lo_nib_mode, .i_hi_nib_mode, .i_byte_mode, .i_bit_dir_out, .i_open_drain, .i_hs0_en,
    .i_hs1_en, .i_hs2_en, .i_share_en, .i_float_req, .i_ext_timing_clr, .i_wr_p0, .i_wr_p1,
    .i_wr_p2, .o_rd_p0, .o_rd_p1, .o_rd_p2, .i_mem_req, .i_mem_wr, .i_mem_addr, .i_mem_wdata,
    .o_mem_ready, .o_mem_rdata, .o_mem_internal, .o_core_rst, .o_ext_timing, .o_start_pc,
    .o_transfer_strobe_n, .o_addr_latch_strobe_n, .o_rd_wr_n, .o_strobe_oe,
    .i_high_addr_port_lines, .o_high_addr_port_lines, .o_high_addr_port_oe,
    .i_muxed_bus_port_lines, .o_muxed_bus_port_lines, .o_muxed_bus_port_oe,
    .i_bit_io_port_lines, .o_bit_io_port_lines, .o_bit_io_port_oe, .i_ctl_line_1, .i_ctl_line_2,
    .i_ctl_line_3, .o_ctl_line_4, .o_ctl_line_5, .o_ctl_line_6);
  iopb_ext_mem iopb_ext_mem_i (.i_clk, .i_as_n(o_addr_latch_strobe_n),
    .i_ds_n(o_transfer_strobe_n), .i_rw_n(o_rd_wr_n), .i_hi(o_high_addr_port_lines),
    .i_ad(o_muxed_bus_port_lines), .o_ad(mem_ad));
  always #10 i_clk = ~i_clk;
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // request held until ready, then one idle cycle before the next
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [7:0] d, output int n);
    {i_mem_wr, i_mem_addr, i_mem_wdata, i_mem_req} = {wr, a, d, 1'b1};
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_mem_ready !== 1'b1 && n < 30);
    if (n == 30) begin
      chk("mem_ready", 1, 0);
      end_of_test;
    end
    tick(1);
    i_mem_req = 1'b0;
    tick(1);
  endtask
  // power-up hold is scaled from tens of ms to tens of clocks to keep the run short
  task automatic pin_rst(input int len);
    int n;
    n = 0;
    i_ext_rst_n = 1'b0;
    for (int k = 1; k <= len + 40; k++) begin
      @(negedge i_clk);
      n += (o_core_rst === 1'b1);
      tick(1);
      if (k == len) i_ext_rst_n = 1'b1;
    end
    chk("core_rst seen", len > 4, n > 0);
    if (len > 4) begin
      chk("core_rst length", 1, n >= 18 && n >= len - 4);
      chk("start_pc", IOPB_START_ADDR, o_start_pc);
    end
  endtask
  // read results are scored where they appear
  always @(negedge i_clk) begin
    if (o_mem_ready === 1'b1 && i_mem_req && !i_mem_wr && o_mem_internal === 1'b0) begin
      chk("mem_rdata", exp_q.pop_front(), o_mem_rdata);
    end
  end
  initial begin
    logic [15:0] a;
    logic [7:0] d;
    logic [7:0] e;
    int n;
    void'($urandom(32'hC14961EF));
    {i_clk, i_open_drain, i_hs0_en, i_hs1_en, i_hs2_en, i_share_en, i_float_req} = 7'h00;
    {i_ext_timing_clr, i_mem_req, i_mem_wr, i_ctl_line_1, i_ctl_line_2, i_ctl_line_3} = 6'h00;
    {i_sys_rst, i_ext_rst_n, i_rom_disable_n} = 3'h7;
    {i_lo_nib_mode, i_hi_nib_mode, i_byte_mode} = {IOPB_NIB_ADDR, IOPB_NIB_ADDR, IOPB_BYTE_BUS};
    {i_bit_dir_out, i_wr_p0, i_wr_p1, i_wr_p2, i_mem_wdata, i_mem_addr} = 56'h0;
    {i_high_addr_port_lines, i_bit_io_port_lines} = 16'h0000;
    tick(10);
    i_sys_rst = 1'b0;
    pin_rst(4);
    pin_rst(5);
    pin_rst(30);
    $display("test reset filter done");
    i_rom_disable_n = 1'b0;
    pin_rst(6);
    chk("ext_timing", 1, o_ext_timing);
    chk("high_addr_oe", 8'hFF, o_high_addr_port_oe);
    exp_q.push_back(8'h10);
    xfer(1'b0, 16'h0010, 8'h00, n);
    chk("ext_latency", EXT_CYC + WAITS, n);
    i_ext_timing_clr = 1'b1;
    tick(1);
    i_ext_timing_clr = 1'b0;
    tick(1);
    chk("ext_timing", 0, o_ext_timing);
    i_rom_disable_n = 1'b1;
    pin_rst(6);
    $display("test rom disable done");
    for (int i = 0; i < 8; i++) begin
      a = 16'h2100 + 16'($urandom_range(16'hDE00));
      d = 8'($urandom);
      xfer(1'b1, a, d, n);
      exp_q.push_back(d);
      xfer(1'b0, a, 8'h00, n);
      chk("ext_latency", EXT_CYC, n);
    end
    xfer(1'b0, IOPB_ONE_PAGE, 8'h00, n);
    chk("internal_latency", 1, n);
    $display("test transfers done");
    for (int m = 0; m < 2; m++) begin
      {i_float_req, i_share_en, i_ctl_line_3} = m ? 3'h3 : 3'h4;
      {i_mem_wr, i_mem_addr, i_mem_req} = {1'b0, 16'h2000, 1'b1};
      repeat (4) begin
        @(negedge i_clk);
        chk("floated ready", 0, o_mem_ready);
        chk("strobe_oe", 0, o_strobe_oe);
      end
      if (m) chk("bus_request", 0, o_ctl_line_4);
      tick(1);
      {i_float_req, i_ctl_line_3} = 2'h0;
      exp_q.push_back(8'h20);
      xfer(1'b0, 16'h2000, 8'h00, n);
    end
    i_share_en = 1'b0;
    $display("test float done");
    i_byte_mode = IOPB_BYTE_OUT;
    {i_hs0_en, i_hs1_en, i_hs2_en} = 3'h7;
    for (int m = 0; m < 4; m++) begin
      {i_bit_dir_out, i_wr_p2, i_wr_p0, i_wr_p1} = $urandom;
      {i_high_addr_port_lines, i_bit_io_port_lines} = 16'($urandom);
      i_open_drain = m[0];
      i_hi_nib_mode = m[0] ? IOPB_NIB_OUT : IOPB_NIB_IN;
      i_lo_nib_mode = m[1] ? IOPB_NIB_OUT : IOPB_NIB_IN;
      tick(2);
      e = i_open_drain ? i_bit_dir_out & ~i_wr_p2 : i_bit_dir_out;
      chk("p2_oe", e, o_bit_io_port_oe);
      e = i_open_drain ? 8'h00 : i_wr_p2 & i_bit_dir_out;
      chk("p2_out", e, o_bit_io_port_lines & o_bit_io_port_oe);
      chk("p2_in", i_bit_io_port_lines, o_rd_p2);
      chk("p0_oe", {{4{m[0]}}, {4{m[1]}}}, o_high_addr_port_oe);
      chk("p0_out", i_wr_p0, o_high_addr_port_lines);
      chk("p0_in", i_high_addr_port_lines, o_rd_p0);
      chk("p1_oe", 8'hFF, o_muxed_bus_port_oe);
      chk("p1_in", i_wr_p1, o_rd_p1);
      chk("hs0_line", m != 3, o_ctl_line_5);
      chk("hs1_line", 0, o_ctl_line_4);
      chk("hs2_line", !i_bit_dir_out[7], o_ctl_line_6);
    end
    $display("test bit port done");
    chk("pending reads", 0, exp_q.size());
    end_of_test;
  end
endmodule
